//--- design/podc_int_div.v
// two-stage integer output divider working on input enable ticks
// assumes tick_in is a one-cycle enable marking each source clock edge
`default_nettype none
`include "podc_regs.vh"

module podc_int_div (
  input wire mclk_in,
  input wire rstn_in,
  input wire tick_in,
  input wire [1:0] s1_sel_in,
  input wire byp_ok_in,
  input wire [`PODC_S2_W-1:0] s2_ratio_in,
  output reg tick_out,
  output reg cfg_err_out
);

  reg [2:0] s1_cnt_r;
  reg [`PODC_S2_W-1:0] s2_cnt_r;
  reg [2:0] s1_last;
  reg s1_byp;
  wire [`PODC_S2_W-1:0] s2_eff;
  wire s1_done;
  wire s2_byp;

  // ----------------------------------------------------------------
  // stage decode
  // ----------------------------------------------------------------
  // first stage four, five or six
  always @* begin
    s1_byp = 1'b0;
    case (s1_sel_in)
      `PODC_S1_DIV4: s1_last = 3'h3;
      `PODC_S1_DIV5: s1_last = 3'h4;
      `PODC_S1_DIV6: s1_last = 3'h5;
      `PODC_S1_BYPASS: begin
        s1_last = 3'h0;
        s1_byp = byp_ok_in;
      end
      default: s1_last = 3'h3;
    endcase
    // bypass refused falls back to divide by four
    if (s1_sel_in == `PODC_S1_BYPASS && !byp_ok_in) begin
      s1_last = 3'h3;
    end
  end

  // even ratio, odd bit dropped; zero is bypass
  assign s2_eff = {s2_ratio_in[`PODC_S2_W-1:1], 1'b0};
  assign s2_byp = (s2_eff == {`PODC_S2_W{1'b0}});
  assign s1_done = tick_in && (s1_byp || s1_cnt_r == s1_last);

  // ----------------------------------------------------------------
  // counters in series
  // ----------------------------------------------------------------
  // total is first times second stage
  always @(posedge mclk_in) begin
    if (!rstn_in) begin
      s1_cnt_r <= 3'h0;
      s2_cnt_r <= {`PODC_S2_W{1'b0}};
      tick_out <= 1'b0;
      cfg_err_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      cfg_err_out <= s2_ratio_in[0] || (s1_sel_in == `PODC_S1_BYPASS && !byp_ok_in);
      if (tick_in) begin
        s1_cnt_r <= s1_done ? 3'h0 : s1_cnt_r + 3'h1;
      end
      if (s1_done) begin
        if (s2_byp || s2_cnt_r >= s2_eff - {{(`PODC_S2_W-1){1'b0}}, 1'b1}) begin
          s2_cnt_r <= {`PODC_S2_W{1'b0}};
          tick_out <= 1'b1;
        end else begin
          s2_cnt_r <= s2_cnt_r + {{(`PODC_S2_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // podc_int_div
`default_nettype wire

//--- design/podc_regs.vh
// constants for the loop and output divider control block
// assumes one 100 MHz clock; all figures below are fixed by the hardware
`ifndef PODC_REGS_VH
`define PODC_REGS_VH

// ----------------------------------------------------------------
// loop state field codes
// ----------------------------------------------------------------
`define PODC_STATE_NORMAL   2'h0
`define PODC_STATE_FREERUN  2'h1
`define PODC_STATE_HOLDOVER 2'h2

// ----------------------------------------------------------------
// bandwidth codes: 0 = 1.40625 Hz doubling up to 8 = 360 Hz
// ----------------------------------------------------------------
`define PODC_BW_MAX_SEL     4'h8
`define PODC_BW_SYNTH       4'h9
`define PODC_BW_RST         4'h0

// ----------------------------------------------------------------
// integer divider first stage codes and second stage limits
// ----------------------------------------------------------------
`define PODC_S1_DIV4        2'h0
`define PODC_S1_DIV5        2'h1
`define PODC_S1_DIV6        2'h2
`define PODC_S1_BYPASS      2'h3
`define PODC_S2_W           17
`define PODC_S2_MAX         17'h1fffe

// ----------------------------------------------------------------
// upper divider source codes
// ----------------------------------------------------------------
`define PODC_SRC_LOOP_A     3'h0
`define PODC_SRC_LOOP_B     3'h1
`define PODC_SRC_FRAC_A     3'h2

// ----------------------------------------------------------------
// fractional divider fields
// ----------------------------------------------------------------
`define PODC_FN_W           18
`define PODC_FF_W           28
`define PODC_FN_MIN         18'h00004
`define PODC_FN_INT_MIN     18'h00003

// ----------------------------------------------------------------
// phase slope timing
// ----------------------------------------------------------------
`define PODC_CLK_NS         10
`define PODC_SLEW_NS        1000
`define PODC_SLEW_CYC       (`PODC_SLEW_NS / `PODC_CLK_NS)
`define PODC_PH_W           16

`endif

//--- design/podc_top.v
// loop mode, bandwidth, switchover phase and output divider control
// assumes loop, reference and crystal edges arrive as one-cycle enables on mclk_in
// How it works
// - synth mode plus free-run state runs loop from crystal alone
// - synth mode forces fixed bandwidth code, selectable settings ignored
// - other modes select one of nine doubling bandwidths
// - each loop has its own independent bandwidth settings
// - acquisition bandwidth used until lock, then locked bandwidth
// - acquisition disabled means locked bandwidth all the time
// - integer first stage divides by four, five or six
// - second stage bypass or any even ratio up to 131070
// - upper four outputs may bypass first stage for some sources
// - fractional divider divides by twice the mixed number
// - fractional integer part from four to two pow 18 minus one
// - fraction is numerator over two pow 28
// - integer part three allowed when fraction is zero
// - first four dividers pick either loop as source
// - upper four pick loop, fractional divider, reference or crystal
// - per-loop switch mode picks slope limiting or hitless on events
// - hitless keeps output phase unchanged across events
// - slope limiting moves phase gradually at two-bit rate
// - loss of every valid reference enters holdover, triggering event
`default_nettype none
`include "podc_regs.vh"

module podc_top (
  input wire mclk_in,
  input wire rstn_in,
  input wire [1:0] synth_mode_sel_in,
  input wire [3:0] loop_state_field_in,
  input wire [1:0] acq_bw_en_in,
  input wire [7:0] acq_bw_sel_in,
  input wire [7:0] lock_bw_sel_in,
  input wire [1:0] loop_locked_in,
  input wire [7:0] ref_valid_in,
  input wire [3:0] ref_active_in,
  input wire [1:0] switch_phase_mode_sel_in,
  input wire [3:0] phase_slope_rate_sel_in,
  input wire [31:0] ref_phase_in,
  input wire loop_a_tick_in,
  input wire loop_b_tick_in,
  input wire [2:0] ref_tick_in,
  input wire xtal_tick_in,
  input wire [11:0] int_s1_sel_in,
  input wire [101:0] int_s2_ratio_in,
  input wire [3:0] low_src_sel_in,
  input wire [11:0] up_src_sel_in,
  input wire [35:0] frac_int_in,
  input wire [55:0] frac_num_in,
  output wire [7:0] loop_bw_code_out,
  output wire [1:0] loop_xtal_only_out,
  output wire [1:0] holdover_out,
  output wire [1:0] phase_event_out,
  output wire [31:0] phase_out,
  output wire [5:0] int_div_tick_out,
  output wire [1:0] frac_div_clk_out,
  output wire [1:0] frac_div_tick_out,
  output wire [7:0] cfg_err_out
);

  // ----------------------------------------------------------------
  // shared slew timebase
  // ----------------------------------------------------------------
  reg [7:0] slew_cnt_r;
  reg slew_tick_r;
  wire [1:0] loop_tick;
  wire [7:0] src_vec;
  wire [5:0] int_err;

  assign loop_tick = {loop_b_tick_in, loop_a_tick_in};
  assign src_vec = {xtal_tick_in, ref_tick_in, frac_div_tick_out, loop_b_tick_in, loop_a_tick_in};

  // one enable per microsecond paces phase slope steps
  always @(posedge mclk_in) begin
    if (!rstn_in) begin
      slew_cnt_r <= 8'h00;
      slew_tick_r <= 1'b0;
    end else if ({24'h000000, slew_cnt_r} == `PODC_SLEW_CYC - 1) begin
      slew_cnt_r <= 8'h00;
      slew_tick_r <= 1'b1;
    end else begin
      slew_cnt_r <= slew_cnt_r + 8'h01;
      slew_tick_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // per-loop mode, bandwidth and switchover phase
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_loop
      wire synth = synth_mode_sel_in[g];
      wire [1:0] st = loop_state_field_in[2*g+1:2*g];
      wire xtal_only = synth && (st == `PODC_STATE_FREERUN);
      wire [3:0] acq_sel = acq_bw_sel_in[4*g+3:4*g];
      wire [3:0] lock_sel = lock_bw_sel_in[4*g+3:4*g];
      wire [1:0] act_ref = ref_active_in[2*g+1:2*g];
      wire signed [`PODC_PH_W-1:0] ref_ph = ref_phase_in[16*g+15:16*g];
      wire [1:0] slew = phase_slope_rate_sel_in[2*g+1:2*g];
      reg [3:0] bw_pick;
      reg hold_nxt;
      reg hold_r;
      reg [1:0] act_ref_r;
      reg ev_r;
      reg signed [`PODC_PH_W-1:0] bo_r;
      reg signed [`PODC_PH_W-1:0] ph_r;
      wire signed [`PODC_PH_W-1:0] target = ref_ph - bo_r;
      wire signed [`PODC_PH_W:0] diff = {target[`PODC_PH_W-1], target} - {ph_r[`PODC_PH_W-1], ph_r};
      wire signed [`PODC_PH_W:0] step = $signed({{(`PODC_PH_W-3){1'b0}}, 4'h1 << slew});
      wire ev;
      // output flops owned by this loop alone
      // each port slice then has exactly one driver
      reg [3:0] bw_r;
      reg xo_r;
      reg hout_r;
      reg evo_r;
      reg [`PODC_PH_W-1:0] pho_r;

      // nine choices, higher codes clamp to widest
      always @* begin
        bw_pick = (acq_bw_en_in[g] && !loop_locked_in[g]) ? acq_sel : lock_sel;
        if (bw_pick > `PODC_BW_MAX_SEL) begin
          bw_pick = `PODC_BW_MAX_SEL;
        end
        if (synth) begin
          bw_pick = `PODC_BW_SYNTH;
        end
      end

      // holdover once no reference is valid
      always @* begin
        hold_nxt = 1'b0;
        if (!xtal_only) begin
          hold_nxt = (st == `PODC_STATE_HOLDOVER) || (ref_valid_in[4*g+3:4*g] == 4'h0);
        end
      end

      // holdover entry, exit or reference change outside holdover is an event
      assign ev = (hold_nxt != hold_r) || (!hold_nxt && act_ref != act_ref_r);

      // state kept apart for each loop
      always @(posedge mclk_in) begin
        if (!rstn_in) begin
          hold_r <= 1'b0;
          act_ref_r <= 2'h0;
          ev_r <= 1'b0;
          bo_r <= {`PODC_PH_W{1'b0}};
          ph_r <= {`PODC_PH_W{1'b0}};
          bw_r <= `PODC_BW_RST;
          xo_r <= 1'b0;
        end else begin
          hold_r <= hold_nxt;
          act_ref_r <= act_ref;
          ev_r <= ev;
          bw_r <= bw_pick;
          xo_r <= xtal_only;
          if (ev && switch_phase_mode_sel_in[g]) begin
            // build-out offset absorbs the phase step
            bo_r <= ref_ph - ph_r;
          end else if (ev) begin
            // slope mode drops any offset and walks to the new phase
            bo_r <= {`PODC_PH_W{1'b0}};
          end else if (switch_phase_mode_sel_in[g]) begin
            ph_r <= target;
          end else if (slew_tick_r) begin
            if (diff > step) begin
              ph_r <= ph_r + step[`PODC_PH_W-1:0];
            end else if (diff < -step) begin
              ph_r <= ph_r - step[`PODC_PH_W-1:0];
            end else begin
              ph_r <= target;
            end
          end
        end
      end

      // outputs copied from flops
      always @(posedge mclk_in) begin
        if (!rstn_in) begin
          hout_r <= 1'b0;
          evo_r <= 1'b0;
          pho_r <= 16'h0000;
        end else begin
          hout_r <= hold_r;
          evo_r <= ev_r;
          pho_r <= ph_r;
        end
      end

      // port slices wired straight from the flops
      assign loop_bw_code_out[4*g+3:4*g] = bw_r;
      assign loop_xtal_only_out[g] = xo_r;
      assign holdover_out[g] = hout_r;
      assign phase_event_out[g] = evo_r;
      assign phase_out[16*g+15:16*g] = pho_r;
    end
  endgenerate

  // ----------------------------------------------------------------
  // fractional dividers
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_frac
      wire [`PODC_FN_W-1:0] n_val = frac_int_in[18*g+17:18*g];
      wire [`PODC_FF_W-1:0] f_val = frac_num_in[28*g+27:28*g];
      wire tick = low_src_sel_in[2+g] ? loop_b_tick_in : loop_a_tick_in;
      reg [`PODC_FF_W-1:0] acc_r;
      reg [`PODC_FN_W:0] cnt_r;
      // square wave, falling pulse and error flag of this divider
      reg fclk_r;
      reg ftick_r;
      reg ferr_r;
      wire [`PODC_FF_W:0] sum = {1'b0, acc_r} + {1'b0, f_val};
      wire n_ok = (n_val >= `PODC_FN_MIN) ||
                  (n_val == `PODC_FN_INT_MIN && f_val == {`PODC_FF_W{1'b0}});
      // carry adds one tick per 2^28 of accumulated fraction
      wire [`PODC_FN_W:0] half_last = {1'b0, n_val} - {{`PODC_FN_W{1'b0}}, ~sum[`PODC_FF_W]};

      // two half periods of n.f ticks each
      always @(posedge mclk_in) begin
        if (!rstn_in) begin
          acc_r <= {`PODC_FF_W{1'b0}};
          cnt_r <= {(`PODC_FN_W+1){1'b0}};
          fclk_r <= 1'b0;
          ftick_r <= 1'b0;
        end else begin
          ftick_r <= 1'b0;
          if (!n_ok) begin
            // bad setting holds the output quiet
            acc_r <= {`PODC_FF_W{1'b0}};
            cnt_r <= {(`PODC_FN_W+1){1'b0}};
            fclk_r <= 1'b0;
          end else if (tick) begin
            if (cnt_r >= half_last) begin
              cnt_r <= {(`PODC_FN_W+1){1'b0}};
              acc_r <= sum[`PODC_FF_W-1:0];
              fclk_r <= ~fclk_r;
              ftick_r <= fclk_r;
            end else begin
              cnt_r <= cnt_r + {{`PODC_FN_W{1'b0}}, 1'b1};
            end
          end
        end
      end

      always @(posedge mclk_in) begin
        if (!rstn_in) begin
          ferr_r <= 1'b0;
        end else begin
          ferr_r <= ~n_ok;
        end
      end

      // port slices wired straight from the flops
      assign frac_div_clk_out[g] = fclk_r;
      assign frac_div_tick_out[g] = ftick_r;
      assign cfg_err_out[6+g] = ferr_r;
    end
  endgenerate

  // ----------------------------------------------------------------
  // integer dividers and their sources
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_int
      wire [2:0] usel;
      wire src_tick;
      wire byp_ok;
      // registered copy of the divider's setting error
      reg ierr_r;
      if (g < 2) begin : g_low
        assign usel = `PODC_SRC_LOOP_A;
        assign src_tick = loop_tick[low_src_sel_in[g]];
        assign byp_ok = 1'b0;
      end else begin : g_up
        assign usel = up_src_sel_in[3*(g-2)+2:3*(g-2)];
        assign src_tick = src_vec[usel];
        // bypass only off the slower sources
        assign byp_ok = (usel >= `PODC_SRC_FRAC_A);
      end

      podc_int_div u_div (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .tick_in(src_tick),
        .s1_sel_in(int_s1_sel_in[2*g+1:2*g]),
        .byp_ok_in(byp_ok),
        .s2_ratio_in(int_s2_ratio_in[17*g+16:17*g]),
        .tick_out(int_div_tick_out[g]),
        .cfg_err_out(int_err[g])
      );

      always @(posedge mclk_in) begin
        if (!rstn_in) begin
          ierr_r <= 1'b0;
        end else begin
          ierr_r <= int_err[g];
        end
      end

      assign cfg_err_out[g] = ierr_r;
    end
  endgenerate

endmodule // podc_top
`default_nettype wire

//--- test/podc_props.sv
// concurrent checks on the loop and divider control ports
// assumes it is bound onto podc_top; reset is synchronous, active low
`default_nettype none
`include "podc_regs.vh"
module podc_props (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic [1:0] synth_mode_sel_in,
  input wire logic [3:0] loop_state_field_in,
  input wire logic [1:0] acq_bw_en_in,
  input wire logic [7:0] acq_bw_sel_in,
  input wire logic [7:0] lock_bw_sel_in,
  input wire logic [1:0] loop_locked_in,
  input wire logic [7:0] ref_valid_in,
  input wire logic [1:0] switch_phase_mode_sel_in,
  input wire logic [31:0] ref_phase_in,
  input wire logic [11:0] int_s1_sel_in,
  input wire logic [101:0] int_s2_ratio_in,
  input wire logic [7:0] loop_bw_code_out,
  input wire logic [1:0] loop_xtal_only_out,
  input wire logic [1:0] holdover_out,
  input wire logic [1:0] phase_event_out,
  input wire logic [31:0] phase_out,
  input wire logic [5:0] int_div_tick_out,
  input wire logic [7:0] cfg_err_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------
  // helpers
  // --------------
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  // codes above the top bandwidth saturate
  function automatic logic [3:0] clamp(input logic [3:0] c);
    return (c > `PODC_BW_MAX_SEL) ? `PODC_BW_MAX_SEL : c;
  endfunction
  // largest slope step is 1 << 3
  function automatic logic near(input logic [15:0] a, input logic [15:0] b);
    int d;
    d = $signed(a) - $signed(b);
    return (d >= -8) && (d <= 8);
  endfunction
  a_xtal_only_flag: assert property (
    $past(rstn_in, 2) |-> loop_xtal_only_out[0] == $past(synth_mode_sel_in[0] && loop_state_field_in[1:0] == `PODC_STATE_FREERUN))
    else $error("crystal-only flag does not follow its inputs");
  a_synth_bw_fixed: assert property (
    $past(rstn_in, 2) && $past(synth_mode_sel_in[1]) |-> loop_bw_code_out[7:4] == `PODC_BW_SYNTH)
    else $error("synth loop bandwidth code not fixed");
  a_acq_bw_used: assert property (
    $past(rstn_in, 2) && $past(!synth_mode_sel_in[0] && acq_bw_en_in[0] && !loop_locked_in[0])
    |-> loop_bw_code_out[3:0] == clamp($past(acq_bw_sel_in[3:0])))
    else $error("acquisition bandwidth not applied");
  a_lock_bw_used: assert property (
    $past(rstn_in, 2) && $past(!synth_mode_sel_in[1] && !(acq_bw_en_in[1] && !loop_locked_in[1]))
    |-> loop_bw_code_out[7:4] == clamp($past(lock_bw_sel_in[7:4])))
    else $error("locked bandwidth not applied");
  a_holdover_entry: assert property (
    $past(rstn_in, 3) ##0 (ref_valid_in[3:0] == 4'h0 && loop_state_field_in[1:0] == `PODC_STATE_NORMAL) [*4]
    |-> holdover_out[0])
    else $error("holdover not entered after losing all references");
  a_event_on_hold: assert property (
    $rose(holdover_out[0]) |-> phase_event_out[0])
    else $error("no phase event on holdover entry");
  a_hitless_phase_kept: assert property (
    (switch_phase_mode_sel_in[0] && $stable(ref_phase_in[15:0])) [*4] ##0 phase_event_out[0] |-> $stable(phase_out[15:0]))
    else $error("hitless event moved the output phase");
  a_slope_step_bound: assert property (
    $past(rstn_in, 2) && !$past(switch_phase_mode_sel_in[0]) && !$past(switch_phase_mode_sel_in[0], 2)
    |-> near(phase_out[15:0], $past(phase_out[15:0])))
    else $error("phase slope step too large");
  a_int_tick_gap: assert property (
    int_div_tick_out[0] |=> !int_div_tick_out[0] [*3])
    else $error("lower divider pulses closer than four ticks");
  a_int_cfg_err: assert property (
    $past(rstn_in, 3) ##0 (int_s2_ratio_in[0] || int_s1_sel_in[1:0] == `PODC_S1_BYPASS) [*4] |-> cfg_err_out[0])
    else $error("bad lower divider setting not flagged");
endmodule // podc_props
bind podc_top podc_props u_props (.mclk_in, .rstn_in, .synth_mode_sel_in, .loop_state_field_in, .acq_bw_en_in,
  .acq_bw_sel_in, .lock_bw_sel_in, .loop_locked_in, .ref_valid_in, .switch_phase_mode_sel_in, .ref_phase_in,
  .int_s1_sel_in, .int_s2_ratio_in, .loop_bw_code_out, .loop_xtal_only_out, .holdover_out, .phase_event_out,
  .phase_out, .int_div_tick_out, .cfg_err_out);
`default_nettype wire

//--- test/podc_sink_model.sv
// downstream clock sink: measures the spacing of divider output pulses
// assumes every output pulse is one mclk_in cycle wide
`default_nettype none
module podc_sink_model (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic [7:0] tick_in,
  output logic [31:0] period_out [8]
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------
  // period meters
  // --------------
  logic [31:0] gap_r [8];
  // a stale period stays until the next pulse, so callers wait three periods
  always_ff @(posedge mclk_in) begin
    for (int i = 0; i < 8; i++) begin
      if (!rstn_in) begin
        gap_r[i] <= 32'h0;
        period_out[i] <= 32'h0;
      end else if (tick_in[i]) begin
        gap_r[i] <= 32'h1;
        period_out[i] <= gap_r[i];
      end else begin
        gap_r[i] <= gap_r[i] + 32'h1;
      end
    end
  end
endmodule // podc_sink_model
`default_nettype wire

//--- test/test_pll_output_divider_control.sv
// self-checking bench for the loop and output divider control block
// assumes the design compiles first; every source tick input runs each cycle
`default_nettype none
`include "podc_regs.vh"
module test_pll_output_divider_control;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------
  // signals
  // --------------
  logic mclk_in = 1'b0, rstn_in = 1'b0, loop_a_tick_in = 1'b1, loop_b_tick_in = 1'b1, xtal_tick_in = 1'b1;
  logic [1:0] synth_mode_sel_in = '0, acq_bw_en_in = '0, loop_locked_in = '0, switch_phase_mode_sel_in = '0;
  logic [3:0] loop_state_field_in = '0, ref_active_in = '0, phase_slope_rate_sel_in = '0, low_src_sel_in = '0;
  logic [7:0] acq_bw_sel_in = '0, lock_bw_sel_in = '0, ref_valid_in = 8'hff;
  logic [2:0] ref_tick_in = 3'h7, u;
  logic [11:0] int_s1_sel_in = '0, up_src_sel_in = '0;
  logic [16:0] s2;
  logic [31:0] ref_phase_in = '0, rnd = 32'h9615f4a5;
  logic [35:0] frac_int_in = '0;
  logic [55:0] frac_num_in = '0;
  logic [101:0] int_s2_ratio_in = '0;
  logic [31:0] sink_period [8];
  wire [7:0] loop_bw_code_out, cfg_err_out;
  wire [1:0] loop_xtal_only_out, holdover_out, phase_event_out, frac_div_tick_out;
  wire [31:0] phase_out;
  wire [5:0] int_div_tick_out;
  int error_cnt = 0, check_count = 0, ev_cnt = 0, e0;
  podc_top u_dut (.mclk_in, .rstn_in, .synth_mode_sel_in, .loop_state_field_in, .acq_bw_en_in, .acq_bw_sel_in,
    .lock_bw_sel_in, .loop_locked_in, .ref_valid_in, .ref_active_in, .switch_phase_mode_sel_in,
    .phase_slope_rate_sel_in, .ref_phase_in, .loop_a_tick_in, .loop_b_tick_in, .ref_tick_in, .xtal_tick_in,
    .int_s1_sel_in, .int_s2_ratio_in, .low_src_sel_in, .up_src_sel_in, .frac_int_in, .frac_num_in,
    .loop_bw_code_out, .loop_xtal_only_out, .holdover_out, .phase_event_out, .phase_out, .int_div_tick_out,
    .frac_div_clk_out(), .frac_div_tick_out, .cfg_err_out);
  podc_sink_model u_sink (.mclk_in, .rstn_in, .tick_in({frac_div_tick_out, int_div_tick_out}),
    .period_out(sink_period));
  // 100 MHz clock
  always #5 mclk_in = ~mclk_in;
  // count phase event pulses, so a doubled pulse shows up
  always @(posedge mclk_in) if (phase_event_out[0] === 1'b1) ev_cnt++;
  // --------------
  // helpers
  // --------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_bw(input logic syn, en, lk, input logic [3:0] a, l);
    logic [3:0] c;
    c = (en && !lk) ? a : l;
    return syn ? 32'h9 : ((c > 4'h8) ? 32'h8 : 32'(c));
  endfunction
  function automatic logic [31:0] int_ratio(input int s1, input logic [16:0] r);
    return (s1 + 4) * ((r == 17'h0) ? 1 : r);
  endfunction
  // inputs move 1 ns after the edge, never on it
  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    check_count++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  // wait three times both periods plus eight cycles, then read lower divider 0 and upper divider 5
  task automatic int_case(input logic [1:0] s1, input logic [16:0] r, input logic [2:0] us,
                          input logic [31:0] plo, input logic [31:0] pup, input logic [5:0] err);
    int_s1_sel_in = {6{s1}};
    int_s2_ratio_in = {6{r}};
    up_src_sel_in = {4{us}};
    step(3 * (plo + pup) + 8);
    chk(sink_period[0], plo);
    chk(sink_period[5], pup);
    chk(cfg_err_out[5:0], err);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // --------------
  // sequence
  // --------------
  initial begin
    step(16);
    rstn_in = 1'b1;
    step(2);
    // random bandwidth and mode settings on both loops
    repeat (40) begin
      rnd = lfsr(lfsr(rnd));
      {synth_mode_sel_in, acq_bw_en_in, loop_locked_in, acq_bw_sel_in, lock_bw_sel_in} = rnd[21:0];
      loop_state_field_in = rnd[25:22];
      step(2);
      for (int i = 0; i < 2; i++) begin
        chk(loop_bw_code_out[4*i+:4], exp_bw(synth_mode_sel_in[i], acq_bw_en_in[i], loop_locked_in[i],
            acq_bw_sel_in[4*i+:4], lock_bw_sel_in[4*i+:4]));
        chk(loop_xtal_only_out[i], synth_mode_sel_in[i] && loop_state_field_in[2*i+:2] == `PODC_STATE_FREERUN);
      end
    end
    synth_mode_sel_in = 2'h0;
    loop_state_field_in = 4'h0;
    // first stage bypass: crystal source allowed, loop source refused, odd second stage
    int_case(2'h3, 17'h2, 3'h7, 32'h8, 32'h2, 6'h03);
    int_case(2'h3, 17'h2, 3'h0, 32'h8, 32'h8, 6'h3f);
    int_case(2'h3, 17'h3, 3'h0, 32'h8, 32'h8, 6'h3f);
    // fractional dividers feeding upper outputs through a bypassed first stage
    frac_int_in = {2{18'h3}};
    int_case(2'h3, 17'h0, 3'h2, 32'h4, 32'h6, 6'h03);
    chk(cfg_err_out[7:6], 2'h0);
    frac_int_in = {2{18'h5}};
    frac_num_in = {2{28'h8000000}};
    int_case(2'h3, 17'h0, 3'h3, 32'h4, 32'hb, 6'h03);
    chk(sink_period[6], 32'hb);
    frac_int_in = {2{18'h3}};
    frac_num_in = {2{28'h1}};
    step(3);
    chk(cfg_err_out[7:6], 2'h3);
    frac_int_in = {2{18'h2}};
    step(3);
    chk(cfg_err_out[7:6], 2'h3);
    // ratio table, second stage rising with j; first stage falls from six to four, so its counter can sit past the new terminal count
    for (int j = 0; j < 4; j++) begin
      for (int k = 0; k < 3; k++) begin
        rnd = lfsr(lfsr(rnd));
        s2 = (j == 3) ? 17'ha + {13'h0, rnd[2:0], 1'b0} : 17'(j * (j + 1));
        low_src_sel_in = rnd[7:4];
        u = rnd[10:8];
        if (u[2:1] == 2'b01) u = 3'h7;
        int_case(2'(k), s2, u, int_ratio(k, s2), int_ratio(k, s2), 6'h00);
      end
    end
    // hitless is used here with no external loopback
    switch_phase_mode_sel_in = 2'h3;
    phase_slope_rate_sel_in = 4'h2;
    ref_phase_in = 32'h64;
    step(20);
    e0 = ev_cnt;
    chk(phase_out[15:0], 16'h64);
    ref_valid_in = 8'hf0;
    step(4);
    chk(holdover_out[0], 1'b1);
    ref_valid_in = 8'hff;
    step(8);
    ref_active_in = 4'h1;
    ref_phase_in = 32'h12c;
    step(8);
    chk(phase_out[15:0], 16'h64);
    chk(ev_cnt - e0, 32'h3);
    // slope mode: step of 4 every 100 cycles toward the new target
    switch_phase_mode_sel_in = 2'h0;
    ref_valid_in = 8'hf0;
    step(1000);
    chk_rng(phase_out[15:0], 32'h84, 32'h94);
    // crystal-only loop ignores lost references
    synth_mode_sel_in = 2'h1;
    loop_state_field_in = 4'h1;
    step(4);
    chk(holdover_out[0], 1'b0);
    report_and_stop;
  end
  // watchdog: the planned run is under 4500 cycles
  initial begin
    #300000;
    error_cnt++;
    report_and_stop;
  end
endmodule // test_pll_output_divider_control
`default_nettype wire
